/* hdl/pwb_output_b_action_logic.v */
/*
  Second-output action logic for three pulse generators, with an APB
  slave holding one action register per generator and a status word.
  Register map, one aligned word each:
    0x064, 0x0a4, 0x0e4  action fields of generators 0, 1 and 2
    0x0f0                last event and output level per generator
  Every transfer takes one wait state; the answer stands one cycle.
  Unmapped addresses and writes to the status word answer an error.
  Assumes counter and comparator pulses are one mclk wide, synchronous
  to mclk, and that countDown tells the present count direction.
*/
// Our own choice: the APB slave port.
`include "pwb_defines.vh"

module pwb_output_b_action_logic
#(
  parameter NUM_GEN = 3
)
(
  input  wire               mclk,            // Module clock, 200 MHz
  input  wire               resetn,          // Synchronous reset, active low
  input  wire               psel,            // APB select
  input  wire               penable,         // APB access phase
  input  wire               pwrite,          // APB write when high
  input  wire [11:0]        paddr,           // APB byte address
  input  wire [31:0]        pwdata,          // APB write data
  output reg  [31:0]        prdata,          // APB read data
  output reg                pready,          // APB transfer done
  output reg                pslverr,         // APB error answer
  input  wire [NUM_GEN-1:0] cntZero,         // Counter reached zero, pulse
  input  wire [NUM_GEN-1:0] cntLoad,         // Counter hit load value, pulse
  input  wire [NUM_GEN-1:0] cmpAMatch,       // Comparator A match, pulse
  input  wire [NUM_GEN-1:0] cmpBMatch,       // Comparator B match, pulse
  input  wire [NUM_GEN-1:0] countDown,       // Counter is counting down
  input  wire [NUM_GEN-1:0] upDownMode,      // Generator mode bit, 1 up/down
  output wire [NUM_GEN-1:0] genSecondOutput  // Second output per generator
);

  localparam AW = `PWB_ACT_W;

  // Bus handshake: idle, or answering for exactly one cycle
  localparam BUS_IDLE   = 1'b0;
  localparam BUS_ANSWER = 1'b1;

  // Register file storage
  reg  [AW-1:0]        actions [0:NUM_GEN-1];

  // Per-generator event resolution
  reg  [NUM_GEN-1:0]   fire;
  reg  [2*NUM_GEN-1:0] winCode;
  reg  [3*NUM_GEN-1:0] winEvent;
  wire [NUM_GEN-1:0]   outLevel;
  wire [3*NUM_GEN-1:0] lastEvent;

  // Bus decode
  wire                 access;
  wire                 takeEdge;
  reg                  next_pready;
  reg                  next_pslverr;
  reg  [31:0]          next_prdata;
  reg  [31:0]          statusWord;
  wire [1:0]           regIndex;
  wire                 hitAction;
  wire                 hitStatus;
  reg                  busState;
  reg                  next_busState;
  integer              resIdx;
  integer              statIdx;
  integer              clrIdx;

  // Index of the action register at an address, 3 when none
  function [1:0] genIndex;
    input [11:0] addr;
    begin
      case (addr)
        `PWB_GEN0_OFS: genIndex = 2'h0;
        `PWB_GEN1_OFS: genIndex = 2'h1;
        `PWB_GEN2_OFS: genIndex = 2'h2;
        default:       genIndex = 2'h3;
      endcase
    end
  endfunction

  // Winning event with fixed priority
  function [2:0] pickEvent;
    input zero;
    input load;
    input aMatch;
    input bMatch;
    input upCount;
    begin
      if (zero)                                    // [R7]
      begin
        pickEvent = `PWB_EV_ZERO;
      end
      else if (load)                               // [R7]
      begin
        pickEvent = `PWB_EV_LOAD;
      end
      else if (bMatch)                             // [R8]
      begin
        pickEvent = upCount ? `PWB_EV_CBU : `PWB_EV_CBD;
      end
      else if (aMatch)
      begin
        pickEvent = upCount ? `PWB_EV_CAU : `PWB_EV_CAD;
      end
      else
      begin
        pickEvent = `PWB_EV_NONE;
      end
    end
  endfunction

  // Action field belonging to an event
  function [1:0] fieldOf;
    input [AW-1:0] act;
    input [2:0]    ev;
    begin
      case (ev)
        `PWB_EV_ZERO: fieldOf = act[`PWB_ZERO_LSB+1:`PWB_ZERO_LSB]; // [R3]
        `PWB_EV_LOAD: fieldOf = act[`PWB_LOAD_LSB+1:`PWB_LOAD_LSB]; // [R2]
        `PWB_EV_CAU:  fieldOf = act[`PWB_CAU_LSB+1:`PWB_CAU_LSB];   // [R10]
        `PWB_EV_CAD:  fieldOf = act[`PWB_CAD_LSB+1:`PWB_CAD_LSB];   // [R10]
        `PWB_EV_CBU:  fieldOf = act[`PWB_CBU_LSB+1:`PWB_CBU_LSB];   // [R10]
        `PWB_EV_CBD:  fieldOf = act[`PWB_CBD_LSB+1:`PWB_CBD_LSB];   // [R10]
        default:      fieldOf = `PWB_ACT_KEEP;
      endcase
    end
  endfunction

  // Event qualification and priority, one generator per pass
  always @*
  begin : resolve
    reg       upCount;
    reg [2:0] ev;
    upCount  = 1'b0;
    ev       = `PWB_EV_NONE;
    fire     = {NUM_GEN{1'b0}};
    winCode  = {2*NUM_GEN{1'b0}};
    winEvent = {3*NUM_GEN{1'b0}};
    for (resIdx = 0; resIdx < NUM_GEN; resIdx = resIdx + 1)
    begin
      // Down-only mode folds every match into a down event
      upCount = upDownMode[resIdx] & ~countDown[resIdx];                 // [R5] [R6] [R11]
      ev = pickEvent(cntZero[resIdx], cntLoad[resIdx], cmpAMatch[resIdx], // [R4]
                     cmpBMatch[resIdx], upCount);
      fire[resIdx]            = (ev != `PWB_EV_NONE);
      winEvent[3*resIdx +: 3] = ev;
      winCode[2*resIdx +: 2]  = fieldOf(actions[resIdx], ev);            // [R9]
    end
  end

  genvar u;
  generate
    for (u = 0; u < NUM_GEN; u = u + 1)
    begin : unit
      pwb_output_unit out_unit
      (
        .mclk       (mclk),
        .resetn     (resetn),
        .fire       (fire[u]),
        .actionCode (winCode[2*u +: 2]),
        .eventCode  (winEvent[3*u +: 3]),
        .outLevel   (outLevel[u]),
        .lastEvent  (lastEvent[3*u +: 3])
      );
    end
  endgenerate

  // Output flops live inside each unit
  assign genSecondOutput = outLevel;

  // Status: last event per generator and present output levels
  always @*
  begin
    statusWord = 32'h0;
    for (statIdx = 0; statIdx < NUM_GEN; statIdx = statIdx + 1)
    begin
      statusWord[`PWB_ST_EV_STRIDE*statIdx +: 3] = lastEvent[3*statIdx +: 3];
      statusWord[`PWB_ST_OUT_LSB + statIdx]      = outLevel[statIdx];
    end
  end

  // One wait state: pready rises one edge into the access phase
  assign access    = psel & penable;
  assign takeEdge  = access & pready;
  assign regIndex  = genIndex(paddr);
  assign hitAction = (regIndex < NUM_GEN);
  assign hitStatus = (paddr == `PWB_STATUS_OFS);

  // A held access phase must not be answered twice, hence the answer state
  always @*
  begin
    next_busState = BUS_IDLE;
    case (busState)
      BUS_IDLE:
      begin
        if (access)
        begin
          next_busState = BUS_ANSWER;
        end
      end
      BUS_ANSWER:
      begin
        next_busState = BUS_IDLE;
      end
      default:
      begin
        next_busState = BUS_IDLE;
      end
    endcase
  end

  always @*
  begin
    next_pready  = (next_busState == BUS_ANSWER);
    next_pslverr = 1'b0;
    next_prdata  = 32'h0;
    if (next_pready)
    begin
      if (hitStatus)
      begin
        next_prdata  = statusWord;
        // Status is read-only; a write is answered with an error
        next_pslverr = pwrite;
      end
      else if (hitAction)
      begin
        next_prdata = {{(32-AW){1'b0}}, actions[regIndex]};
      end
      else
      begin
        next_pslverr = 1'b1;
      end
    end
  end

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      busState <= BUS_IDLE;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0;
    end
    else
    begin
      busState <= next_busState;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
      prdata   <= next_prdata;
    end
  end

  // Writes land on the edge where the master sees pready
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      for (clrIdx = 0; clrIdx < NUM_GEN; clrIdx = clrIdx + 1)
      begin
        actions[clrIdx] <= `PWB_ACT_RESET;                  // [R2] [R3]
      end
    end
    else if (takeEdge && pwrite && hitAction)
    begin
      actions[regIndex] <= pwdata[AW-1:0];                  // [R9]
    end
  end

endmodule

/* hdl/pwb_defines.vh */
/*
  Constants for the second-output action logic of three pulse generators:
  register offsets, action field positions, action codes, event codes.
  Assumes it is included by bare name from the design files under hdl/.
*/
// Operation
// R1 - Codes: keep, invert, clear, set
// R2 - Load match applies field 3:2, reset zero
// R3 - Counter zero applies field 1:0, reset zero
// R4 - Output driven by zero, load, compare pulses
// R5 - Down mode yields only four event kinds
// R6 - Up/down mode yields all six events
// R7 - Zero or load beats any compare
// R8 - Compare B beats compare A
// R9 - Three registers, one per generator output
// R10 - Compare fields at 11:10, 9:8, 7:6, 5:4
// R11 - Up-count compares only in up/down mode
// R12 - Output holds between events and on keep
`ifndef PWB_DEFINES_VH
`define PWB_DEFINES_VH

// Register byte offsets
`define PWB_GEN0_OFS     12'h064
`define PWB_GEN1_OFS     12'h0a4
`define PWB_GEN2_OFS     12'h0e4
`define PWB_STATUS_OFS   12'h0f0

// Action field layout
`define PWB_ACT_W        12
`define PWB_ZERO_LSB     0
`define PWB_LOAD_LSB     2
`define PWB_CAU_LSB      4
`define PWB_CAD_LSB      6
`define PWB_CBU_LSB      8
`define PWB_CBD_LSB      10
`define PWB_ACT_RESET    12'h000

// Action codes
`define PWB_ACT_KEEP     2'h0
`define PWB_ACT_INVERT   2'h1
`define PWB_ACT_CLEAR    2'h2
`define PWB_ACT_SET      2'h3

// Event codes, also shown in the status register
`define PWB_EV_NONE      3'h0
`define PWB_EV_ZERO      3'h1
`define PWB_EV_LOAD      3'h2
`define PWB_EV_CAU       3'h3
`define PWB_EV_CAD       3'h4
`define PWB_EV_CBU       3'h5
`define PWB_EV_CBD       3'h6

// Status register layout
`define PWB_ST_EV_STRIDE 4
`define PWB_ST_OUT_LSB   16

`endif

/* hdl/pwb_output_unit.v */
/*
  One generator's second output: applies the chosen action code to the
  output flop and remembers which event was last taken.
  Assumes the caller has already resolved event priority.
*/
`include "pwb_defines.vh"

module pwb_output_unit
(
  input  wire       mclk,       // Module clock
  input  wire       resetn,     // Synchronous reset, active low
  input  wire       fire,       // An event won this cycle
  input  wire [1:0] actionCode, // Action of the winning event
  input  wire [2:0] eventCode,  // Kind of the winning event
  output reg        outLevel,   // Generator second output
  output reg  [2:0] lastEvent   // Last event taken
);

  function applyAction;
    input       cur;
    input [1:0] code;
    begin
      case (code)
        `PWB_ACT_KEEP:   applyAction = cur;   // [R1] [R12]
        `PWB_ACT_INVERT: applyAction = ~cur;  // [R1]
        `PWB_ACT_CLEAR:  applyAction = 1'b0;  // [R1]
        `PWB_ACT_SET:    applyAction = 1'b1;  // [R1]
        default:         applyAction = cur;
      endcase
    end
  endfunction

  reg next_outLevel;

  always @*
  begin
    next_outLevel = outLevel; // [R12]
    if (fire)
    begin
      next_outLevel = applyAction(outLevel, actionCode);
    end
  end

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      outLevel  <= 1'b0;
      lastEvent <= `PWB_EV_NONE;
    end
    else
    begin
      outLevel <= next_outLevel;
      if (fire)
      begin
        lastEvent <= eventCode;
      end
    end
  end

endmodule

/* testbench/pwb_asserts.sv */
/* Checker for the second-output action logic, generators 0 and 1.
   Bound to the top module; sees only its ports. */
module pwb_asserts
#(
  parameter NUM_GEN = 3
)
(
  input logic               mclk,           // Clock
  input logic               resetn,         // Reset
  input logic               psel,           // Bus
  input logic               penable,        // Bus
  input logic               pwrite,         // Bus
  input logic [11:0]        paddr,          // Bus
  input logic [31:0]        pwdata,         // Bus
  input logic [31:0]        prdata,         // Bus
  input logic               pready,         // Bus
  input logic [NUM_GEN-1:0] cntZero,        // Event
  input logic [NUM_GEN-1:0] cntLoad,        // Event
  input logic [NUM_GEN-1:0] cmpAMatch,      // Event
  input logic [NUM_GEN-1:0] cmpBMatch,      // Event
  input logic [NUM_GEN-1:0] countDown,      // Mode
  input logic [NUM_GEN-1:0] upDownMode,     // Mode
  input logic [NUM_GEN-1:0] genSecondOutput // Output
);
  logic [11:0] act;
  logic [1:0]  code;
  logic        o, nx, up, ev;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // Shadow of gen0 actions; a same-cycle event still sees the old value
  always_ff @(posedge mclk)
    if (!resetn)
      act <= 12'h000;
    else if (psel && penable && pready && pwrite && paddr == 12'h064)
      act <= pwdata[11:0];
  assign o = genSecondOutput[0];
  assign up = upDownMode[0] && !countDown[0];
  assign ev = cntZero[0] || cntLoad[0];
  assign code = cntZero[0] ? act[1:0] : cntLoad[0] ? act[3:2] :
                cmpBMatch[0] ? (up ? act[9:8] : act[11:10]) :
                cmpAMatch[0] ? (up ? act[5:4] : act[7:6]) : 2'h0;
  assign nx = code == 2'h0 ? o : code == 2'h1 ? !o : code[0];
  a_zero_first: assert property (cntZero[0] |=> o == $past(nx))
    else $error("zero action wrong");
  a_load_next: assert property (cntLoad[0] |=> o == $past(nx))
    else $error("load action wrong");
  a_b_over_a: assert property (cmpBMatch[0] && !ev |=> o == $past(nx))
    else $error("compare B action wrong");
  a_a_action: assert property (cmpAMatch[0] |=> o == $past(nx))
    else $error("compare A action wrong");
  a_keep_holds: assert property (code == 2'h0 |=> $stable(o))
    else $error("output moved without action");
  a_force_level: assert property (code[1] |=> o == $past(code[0]))
    else $error("forced level wrong");
  a_gen1_idle: assert property (
    !(cntZero[1] || cntLoad[1] || cmpAMatch[1] || cmpBMatch[1])
    |=> $stable(genSecondOutput[1]))
    else $error("idle generator output moved");
  a_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer timing wrong");
  a_read_back: assert property (
    pready && !pwrite && paddr == 12'h064 |-> prdata == {20'h0, act})
    else $error("register read wrong");
  c_zero_cmp: cover property (cntZero[0] && cmpAMatch[0]);
  c_both_cmp: cover property (cmpAMatch[0] && cmpBMatch[0]);
  c_read: cover property (pready && !pwrite);
endmodule

bind pwb_output_b_action_logic pwb_asserts #(.NUM_GEN(NUM_GEN)) u_pwb_asserts (
  .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .cntZero(cntZero), .cntLoad(cntLoad), .cmpAMatch(cmpAMatch), .cmpBMatch(cmpBMatch),
  .countDown(countDown), .upDownMode(upDownMode), .genSecondOutput(genSecondOutput));

/* testbench/pwb_tb.sv */
/* Self-checking bench for the second-output action logic.
   Drives the APB slave and the event pulses itself; no partner model. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, o = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [11:0] evs = 12'h000; // cmpB, cmpA, load, zero
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0]  dn = 3'h0, ud = 3'h7, out;
  int          n_fail = 0, comparisons = 0;

  pwb_output_b_action_logic u_pwb_output_b_action_logic (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cntZero(evs[2:0]), .cntLoad(evs[5:3]), .cmpAMatch(evs[8:6]), .cmpBMatch(evs[11:9]),
    .countDown(dn), .upDownMode(ud), .genSecondOutput(out));

  initial
    forever #2.5 mclk = ~mclk;

  task automatic finish_test;
    $display("compared %0d, failed %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until the rising edge at which pready is seen high
  task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d,
                      input logic [31:0] e, input logic er);
    int i;
    i = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && i < 16)
    begin
      i++;
      @(posedge mclk);
    end
    if (i == 16)
    begin
      n_fail++;
      $display("[FAIL] %0t pready never came", $time);
      finish_test();
    end
    else
    begin
      if (!w)
        chk(prdata, e);
      chk({31'h0, pslverr}, {31'h0, er});
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic ev(input logic [11:0] e, input logic [2:0] ex);
    @(posedge mclk);
    evs <= e;
    @(posedge mclk);
    evs <= 12'h000;
    @(negedge mclk);
    chk({29'h0, out}, {29'h0, ex});
  endtask

  initial
  begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    xfer(0, 12'h064, 0, 0, 0);
    xfer(0, 12'h0e4, 0, 0, 0);
    xfer(0, 12'h000, 0, 0, 1);
    xfer(1, 12'h064, 32'hfffffb67, 0, 0);
    xfer(0, 12'h064, 0, 32'h00000b67, 0);
    $display("test 1 done");
    ev(12'h001, 3'h1);
    ev(12'h008, 3'h0);
    ev(12'h041, 3'h1);
    ev(12'h048, 3'h0);
    ev(12'h200, 3'h1);
    ev(12'h040, 3'h0);
    @(posedge mclk) dn <= 3'h1;
    ev(12'h040, 3'h1);
    ev(12'h240, 3'h0);
    ev(12'h000, 3'h0);
    @(posedge mclk);
    ud <= 3'h6;
    dn <= 3'h0;
    ev(12'h040, 3'h1);
    $display("test 2 done");
    for (int c = 3; c >= 0; c--)
    begin
      xfer(1, 12'h0a4, 32'(c), 0, 0);
      o = c == 0 ? o : c == 1 ? !o : c[0];
      ev(12'h002, {1'b0, o, 1'b1});
    end
    xfer(1, 12'h0e4, 32'h0000000c, 0, 0);
    ev(12'h020, {1'b1, o, 1'b1});
    xfer(1, 12'h0f0, 32'h0, 0, 1);
    xfer(0, 12'h0f0, 0, 32'h00070214, 0);
    $display("test 3 done");
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    chk({29'h0, out}, 32'h0);
    xfer(0, 12'h064, 0, 0, 0);
    $display("test 4 done");
    finish_test();
  end
endmodule
